// ===== core/mlfd_map.vh
`ifndef MLFD_MAP_VH
`define MLFD_MAP_VH
// Register byte addresses
`define MLFD_A_CTRL 8'h00
`define MLFD_A_MOTOR 8'h04
`define MLFD_A_LIMIT 8'h08
`define MLFD_A_FAULT 8'h0C
`define MLFD_A_STATUS 8'h10
// Control register fields
`define MLFD_CTRL_LOCK_SCHEME_ENABLE 5:0
`define MLFD_CTRL_MECH_EN 8
`define MLFD_CTRL_IND_EN 9
`define MLFD_CTRL_MECH_MD 10
`define MLFD_CTRL_RUN 16
`define MLFD_CTRL_RST 32'h0000_073F
// Motor register fields
`define MLFD_MOT_RM 6:0
`define MLFD_MOT_KT 14:8
`define MLFD_MOT_KTRNG 17:16
`define MLFD_MOT_RST 32'h0000_0000
// Limit register fields
`define MLFD_LIM_SW 3:0
`define MLFD_LIM_HW 6:4
`define MLFD_LIM_BRKTHR 11:8
`define MLFD_LIM_BRKDONE 14:12
`define MLFD_LIM_RST 32'h0000_1070
// Lock flag bit positions
`define MLFD_F_CURLIM 0
`define MLFD_F_SPEED 1
`define MLFD_F_KT 2
`define MLFD_F_NOMOTOR 3
`define MLFD_F_OLSTUCK 4
`define MLFD_F_CLSTUCK 5
`define MLFD_F_OVERCUR 6
// Scaling of thresholds
`define MLFD_CUR_STEP 12'h010
`define MLFD_HW_STEP 12'h080
`define MLFD_NOMOTOR_MA 12'h08C
`define MLFD_BRK_STEP 12'h010
`define MLFD_BRK_UNIT 16
// Timing figures in microseconds at 100 cycles per microsecond
`define MLFD_CYC_PER_US 100
`define MLFD_LOCK_OFF_US 5000000
`define MLFD_ESTIMATE_US 100000
`define MLFD_BRK_UNIT_US 1000
// Bus responses
`define MLFD_RESP_OKAY 2'b00
`define MLFD_RESP_SLVERR 2'b10
`endif

// ===== core/mlfd_top.v
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "mlfd_map.vh"

module mlfd_top #(
    parameter VW = 12,
    parameter LOCK_OFF_CYC = `MLFD_LOCK_OFF_US * `MLFD_CYC_PER_US,
    parameter ESTIMATE_CYC = `MLFD_ESTIMATE_US * `MLFD_CYC_PER_US,
    parameter BRK_UNIT_CYC = `MLFD_BRK_UNIT_US * `MLFD_CYC_PER_US
) (
    input wire i_clk,
    input wire i_rstn,
    input wire [7:0] i_awaddr,
    input wire i_awvalid,
    output reg o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output reg o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    output reg o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    input wire i_closed_loop,
    input wire i_handoff,
    input wire i_bemf_seen,
    input wire i_ecycle_pulse,
    input wire i_halfcycle_pulse,
    input wire i_commutate,
    input wire i_short_circuit,
    input wire i_vcc_24v,
    input wire [VW-1:0] i_speed,
    input wire [VW-1:0] i_bemf,
    input wire [VW-1:0] i_lowside_ma,
    input wire [VW-1:0] i_phase_u_ma,
    input wire [VW-1:0] i_vcmd,
    output reg [VW-1:0] o_vapplied,
    output reg o_drive_en,
    output reg o_brake,
    output reg o_hiz,
    output reg o_restart
);
    localparam ST_RUN = 2'd0;
    localparam ST_BRAKE = 2'd1;
    localparam ST_OFF = 2'd2;
    localparam CW = 32;

    reg [31:0] ctrl_q;
    reg [31:0] motor_q;
    reg [31:0] limit_q;
    reg [6:0] flags_q;
    reg [6:0] flags_d;
    reg [1:0] st_q;
    reg [CW-1:0] tmr_q;
    reg [CW-1:0] spd_cnt_q;
    reg [CW-1:0] kt_cnt_q;
    reg [CW-1:0] per_q;
    reg [CW-1:0] prev_per_q;
    reg [VW+7:0] kt_acc_q;
    reg [VW+7:0] kt_meas_q;
    reg ol_wait_q;
    reg ol_check_q;
    reg aw_ok_q;
    reg w_ok_q;
    reg [7:0] aw_q;
    reg [31:0] wd_q;
    reg [3:0] ws_q;

    wire [6:0] rm = motor_q[`MLFD_MOT_RM];
    wire [6:0] kt = motor_q[`MLFD_MOT_KT];
    // Operands are sized to the wide path so no product loses its top bits
    wire [VW+7:0] bemf_kt = ({8'h00, i_speed} * {{(VW+4){1'b0}}, kt[3:0]}) << kt[6:4];
    wire [VW+7:0] bemf_rm = ({8'h00, i_phase_u_ma} * {{(VW+4){1'b0}}, rm[3:0]}) << rm[6:4];
    // Current limit in mA, then the resistive drop it allows
    wire [VW+7:0] ilim_ma = {{(VW+4){1'b0}}, limit_q[`MLFD_LIM_SW]} * {8'h00, `MLFD_CUR_STEP};
    wire [VW+7:0] ir_drop = ilim_ma * {{(VW+1){1'b0}}, rm};
    wire [VW+7:0] cap = ir_drop + bemf_kt;
    wire [VW+7:0] vcmd_w = {8'h00, i_vcmd};
    wire [VW+7:0] kt_ref = {1'b0, kt, {VW{1'b0}}} >> 4;
    wire [2:0] kt_sh = 3'd3 - {1'b0, motor_q[`MLFD_MOT_KTRNG]};
    wire [VW+7:0] kt_margin = kt_ref >> kt_sh;
    wire [VW+7:0] kt_lo = kt_ref - kt_margin;
    wire [VW+7:0] kt_hi = kt_ref + kt_margin;
    wire [VW-1:0] hw_thr = `MLFD_HW_STEP * {9'd0, limit_q[`MLFD_LIM_HW]} + `MLFD_HW_STEP;
    wire hw_over = i_lowside_ma > hw_thr;
    wire spd_bad = (bemf_rm > vcmd_w) || (bemf_kt > vcmd_w);
    wire kt_bad = (kt_meas_q < kt_lo) || (kt_meas_q > kt_hi);
    wire [VW-1:0] brk_thr = {8'd0, limit_q[`MLFD_LIM_BRKTHR]} * `MLFD_BRK_STEP;
    wire brk_low = i_phase_u_ma < brk_thr;
    wire [2:0] brk_sel = limit_q[`MLFD_LIM_BRKDONE];
    wire [5:0] lock_en = ctrl_q[`MLFD_CTRL_LOCK_SCHEME_ENABLE];
    wire run = st_q == ST_RUN;

    // Detection per scheme, computed combinationally then latched sticky
    reg [6:0] det;
    always @* begin
        det = 7'd0;
        det[`MLFD_F_CURLIM] = hw_over;
        det[`MLFD_F_SPEED] = i_closed_loop && spd_cnt_q >= ESTIMATE_CYC;
        det[`MLFD_F_KT] = i_closed_loop && kt_cnt_q >= ESTIMATE_CYC;
        det[`MLFD_F_NOMOTOR] = i_handoff && (i_phase_u_ma <= `MLFD_NOMOTOR_MA);
        det[`MLFD_F_OLSTUCK] = ol_check_q && i_ecycle_pulse;
        // Checked at each commutation; a rotor that never commutates again is left to the other schemes
        det[`MLFD_F_CLSTUCK] = i_closed_loop && i_commutate && prev_per_q != 0
            && per_q > (prev_per_q << 1);
        det[`MLFD_F_OVERCUR] = i_short_circuit;
    end

    // One shutdown gate per lock scheme; the flags stay independent of these enables
    wire [5:0] trip;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_trip
            assign trip[g] = det[g] && lock_en[g];
        end
    endgenerate

    wire fault = run && ctrl_q[`MLFD_CTRL_RUN] && ((|trip) || det[`MLFD_F_OVERCUR]);

    always @* begin
        flags_d = flags_q | (run ? det : 7'd0);
        // A condition seen in the restart cycle itself survives the clear
        if (o_restart) begin
            flags_d = 7'd0 | det;
        end
    end

    // Voltage clamp: software limit and mechanical surge floor
    reg [VW+7:0] vlim;
    always @* begin
        vlim = vcmd_w;
        if (i_closed_loop && vlim > cap) begin
            vlim = cap;
        end
        if (ctrl_q[`MLFD_CTRL_MECH_EN] && (!ctrl_q[`MLFD_CTRL_MECH_MD] || i_vcc_24v) && vlim < bemf_kt) begin
            vlim = bemf_kt;
        end
    end

    wire [CW-1:0] brk_cyc = {29'd0, brk_sel} * BRK_UNIT_CYC;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= ST_RUN;
            tmr_q <= 32'h0000_0000;
            flags_q <= 7'h00;
            spd_cnt_q <= 32'h0000_0000;
            kt_cnt_q <= 32'h0000_0000;
            per_q <= 32'h0000_0000;
            prev_per_q <= 32'h0000_0000;
            kt_acc_q <= 0;
            kt_meas_q <= 0;
            ol_wait_q <= 1'b0;
            ol_check_q <= 1'b0;
            o_vapplied <= 0;
            o_drive_en <= 1'b0;
            o_brake <= 1'b0;
            o_hiz <= 1'b1;
            o_restart <= 1'b0;
        end else begin
            flags_q <= flags_d;
            o_restart <= 1'b0;
            spd_cnt_q <= (spd_bad && i_closed_loop && run) ? spd_cnt_q + 1'b1 : 32'h0000_0000;
            kt_cnt_q <= (kt_bad && i_closed_loop && run) ? kt_cnt_q + 1'b1 : 32'h0000_0000;
            if (i_halfcycle_pulse) begin
                kt_meas_q <= kt_acc_q;
                // The pulse cycle's own sample opens the next half-cycle, so none is lost
                kt_acc_q <= {8'h00, i_bemf};
            end else begin
                kt_acc_q <= kt_acc_q + {8'h00, i_bemf};
            end
            if (i_commutate) begin
                prev_per_q <= per_q;
                per_q <= 32'h0000_0000;
            end else begin
                per_q <= per_q + 1'b1;
            end
            // Lock_flag_openloop_stuck window: armed after handoff, cleared by back-EMF
            if (i_bemf_seen || !run) begin
                ol_wait_q <= 1'b0;
                ol_check_q <= 1'b0;
            end else if (i_handoff) begin
                ol_wait_q <= 1'b1;
            end else if (ol_wait_q && i_ecycle_pulse) begin
                ol_wait_q <= 1'b0;
                ol_check_q <= 1'b1;
            end
            case (st_q)
                ST_RUN: begin
                    o_vapplied <= vlim[VW-1:0];
                    o_drive_en <= ctrl_q[`MLFD_CTRL_RUN];
                    o_hiz <= !ctrl_q[`MLFD_CTRL_RUN];
                    if (fault) begin
                        tmr_q <= 32'h0000_0000;
                        o_drive_en <= 1'b0;
                        // Brake holds low sides so winding energy is not dumped into the supply
                        if (ctrl_q[`MLFD_CTRL_IND_EN] && brk_sel != 3'd0) begin
                            st_q <= ST_BRAKE;
                            o_brake <= 1'b1;
                            o_hiz <= 1'b0;
                        end else begin
                            st_q <= ST_OFF;
                            o_hiz <= 1'b1;
                        end
                    end
                end
                ST_BRAKE: begin
                    tmr_q <= brk_low ? tmr_q + 1'b1 : 32'h0000_0000;
                    if (brk_low && tmr_q + 1'b1 >= brk_cyc) begin
                        st_q <= ST_OFF;
                        tmr_q <= 32'h0000_0000;
                        o_brake <= 1'b0;
                        o_hiz <= 1'b1;
                    end
                end
                ST_OFF: begin
                    // Flags are kept through the off time so software can still read the cause
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q + 1'b1 >= LOCK_OFF_CYC) begin
                        st_q <= ST_RUN;
                        tmr_q <= 32'h0000_0000;
                        o_restart <= 1'b1;
                    end
                end
                default: begin
                    st_q <= ST_OFF;
                end
            endcase
        end
    end

    // Supervisor snapshot for software, measured Kt in the upper half
    wire [31:0] status_w = {kt_meas_q[15:0], 11'd0, o_brake, o_hiz, o_drive_en, st_q};

    // AXI4-Lite slave; write address and data may arrive in either order
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q <= `MLFD_CTRL_RST;
            motor_q <= `MLFD_MOT_RST;
            limit_q <= `MLFD_LIM_RST;
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= `MLFD_RESP_OKAY;
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `MLFD_RESP_OKAY;
        end else begin
            o_awready <= !aw_ok_q && !o_awready && !o_bvalid && i_awvalid;
            o_wready <= !w_ok_q && !o_wready && !o_bvalid && i_wvalid;
            if (o_awready && i_awvalid) begin
                aw_ok_q <= 1'b1;
                aw_q <= i_awaddr;
            end
            if (o_wready && i_wvalid) begin
                w_ok_q <= 1'b1;
                wd_q <= i_wdata;
                ws_q <= i_wstrb;
            end
            if (aw_ok_q && w_ok_q && !o_bvalid) begin
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= `MLFD_RESP_OKAY;
                case (aw_q)
                    `MLFD_A_CTRL: ctrl_q <= merge(ctrl_q, wd_q, ws_q);
                    `MLFD_A_MOTOR: motor_q <= merge(motor_q, wd_q, ws_q);
                    `MLFD_A_LIMIT: limit_q <= merge(limit_q, wd_q, ws_q);
                    // Read-only registers accept the write without effect
                    `MLFD_A_FAULT: o_bresp <= `MLFD_RESP_OKAY;
                    `MLFD_A_STATUS: o_bresp <= `MLFD_RESP_OKAY;
                    default: o_bresp <= `MLFD_RESP_SLVERR;
                endcase
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            o_arready <= !o_arready && !o_rvalid && i_arvalid;
            if (o_arready && i_arvalid) begin
                o_rvalid <= 1'b1;
                o_rresp <= `MLFD_RESP_OKAY;
                case (i_araddr)
                    `MLFD_A_CTRL: o_rdata <= ctrl_q;
                    `MLFD_A_MOTOR: o_rdata <= motor_q;
                    `MLFD_A_LIMIT: o_rdata <= limit_q;
                    `MLFD_A_FAULT: o_rdata <= {25'd0, flags_q};
                    `MLFD_A_STATUS: o_rdata <= status_w;
                    default: begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= `MLFD_RESP_SLVERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Byte-lane merge for partial writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
            end
        end
    endfunction
endmodule

// ===== verif/mlfd_monitor.sv
`timescale 1ns/100ps
module mlfd_monitor #(
    parameter LOCK_OFF_CYC = 50,
    parameter BRK_UNIT_CYC = 4
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic o_awready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic o_arready,
    input wire logic i_arvalid,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic i_short_circuit,
    input wire logic o_drive_en,
    input wire logic o_brake,
    input wire logic o_hiz,
    input wire logic o_restart
);
    logic [31:0] hiz_cnt_q;
    logic [31:0] brk_cnt_q;
    // Run lengths of the off and brake phases, checked when each phase ends
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hiz_cnt_q <= 32'h0000_0000;
            brk_cnt_q <= 32'h0000_0000;
        end else begin
            hiz_cnt_q <= o_hiz ? hiz_cnt_q + 32'h0000_0001 : 32'h0000_0000;
            brk_cnt_q <= o_brake ? brk_cnt_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    default clocking mlfd_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("write response dropped");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    awready_pulse_a: assert property (o_awready |=> !o_awready) else $error("awready longer than a cycle");
    read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
    short_stop_a: assert property (i_short_circuit && o_drive_en |=> !o_drive_en && (o_hiz || o_brake))
        else $error("short circuit did not stop drive");
    brake_hiz_excl_a: assert property (!(o_brake && o_hiz)) else $error("brake and hiz together");
    brake_drive_excl_a: assert property (!(o_brake && o_drive_en)) else $error("brake while driving");
    restart_pulse_a: assert property (o_restart |=> !o_restart) else $error("restart not a pulse");
    off_time_a: assert property (o_restart |-> hiz_cnt_q >= LOCK_OFF_CYC - 1) else $error("off time short");
    brake_time_a: assert property ($fell(o_brake) |-> brk_cnt_q >= BRK_UNIT_CYC)
        else $error("brake ended early");
    brake_seen_c: cover property ($rose(o_brake));
    restart_seen_c: cover property (o_restart);
    read_done_c: cover property (o_rvalid && i_rready);
endmodule
bind mlfd_top mlfd_monitor #(.LOCK_OFF_CYC(LOCK_OFF_CYC), .BRK_UNIT_CYC(BRK_UNIT_CYC)) mlfd_monitor_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .o_awready(o_awready), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_arready(o_arready), .i_arvalid(i_arvalid), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .i_short_circuit(i_short_circuit), .o_drive_en(o_drive_en), .o_brake(o_brake), .o_hiz(o_hiz),
    .o_restart(o_restart));

// ===== verif/mlfd_motor_model.sv
`timescale 1ns/100ps
module mlfd_motor_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_drive_en,
    input wire logic [11:0] i_load_ma,
    output logic [11:0] o_current_ma
);
    logic [11:0] cur_q;
    // Winding current lags drive by a cycle and halves each cycle once undriven, braked or not
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cur_q <= 12'h000;
        end else if (i_drive_en) begin
            cur_q <= i_load_ma;
        end else begin
            cur_q <= cur_q >> 1;
        end
    end
    assign o_current_ma = cur_q;
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`include "mlfd_map.vh"
module tb_top;
    logic i_clk = 0, i_rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic short_c = 0, closed = 0, saw = 0, vcc24 = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 0;
    logic [4:0] p = 0;
    logic [11:0] vcmd = 0, load = 0, speed = 0, bemf = 0, cur, vapplied;
    logic awready, wready, bvalid, arready, rvalid, drive_en, brake, hiz, restart;
    logic [1:0] bresp, rresp, bresp_q, r;
    int n_errors = 0, n_compared = 0, cyc = 0, k;
    always #5 i_clk = ~i_clk;
    mlfd_top #(.VW(12), .LOCK_OFF_CYC(50), .ESTIMATE_CYC(20), .BRK_UNIT_CYC(4)) mlfd_top_i (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_closed_loop(closed),
        .i_handoff(p[0]), .i_bemf_seen(p[4]), .i_ecycle_pulse(p[1]), .i_halfcycle_pulse(p[3]),
        .i_commutate(p[2]), .i_short_circuit(short_c), .i_vcc_24v(vcc24), .i_speed(speed), .i_bemf(bemf),
        .i_lowside_ma(cur), .i_phase_u_ma(cur), .i_vcmd(vcmd), .o_vapplied(vapplied), .o_drive_en(drive_en),
        .o_brake(brake), .o_hiz(hiz), .o_restart(restart));
    mlfd_motor_model mlfd_motor_model_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_drive_en(drive_en),
        .i_load_ma(load), .o_current_ma(cur));
    task finish_test();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge i_clk);
            if (awready === 1'b1) begin aw_done = 1; awvalid <= 0; end
            if (wready === 1'b1) begin w_done = 1; wvalid <= 0; end
        end
        do @(posedge i_clk); while (bvalid !== 1'b1);
        bresp_q = bresp;
        bready <= 0;
        @(posedge i_clk);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge i_clk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge i_clk); while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 0;
        @(posedge i_clk);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(d, exp);
    endtask
    // Pulses {bemf_seen, halfcycle, commutate, ecycle, handoff} for one cycle, then idles
    task pulse(input logic [4:0] m, input int gap);
        p <= m;
        @(posedge i_clk);
        p <= 5'b00000;
        tick(gap);
    endtask
    task wait_off();
        saw = 0;
        for (k = 0; k < 100 && hiz !== 1'b1; k++) begin @(posedge i_clk); saw |= (brake === 1'b1); end
    endtask
    initial begin
        tick(3);
        i_rstn <= 1;
        @(posedge i_clk);
        rd_chk(`MLFD_A_CTRL, `MLFD_CTRL_RST);
        rd_chk(`MLFD_A_LIMIT, `MLFD_LIM_RST);
        rd_chk(`MLFD_A_MOTOR, `MLFD_MOT_RST);
        rd(8'h14, d, r);
        chk(r, `MLFD_RESP_SLVERR);
        wr(8'h18, 32'h0000_0001);
        chk(bresp_q, `MLFD_RESP_SLVERR);
        wr(`MLFD_A_FAULT, 32'h0000_00FF);
        rd_chk(`MLFD_A_FAULT, 32'h0000_0000);
        // Soft limit 3*16 mA stays below the 128 mA hardware threshold
        wr(`MLFD_A_MOTOR, 32'h0000_0002);
        wr(`MLFD_A_LIMIT, 32'h0000_1103);
        wr(`MLFD_A_CTRL, 32'h0001_0700);
        vcmd <= 12'h1F4;
        tick(4);
        chk(vapplied, 12'h1F4);
        closed <= 1;
        tick(4);
        chk(vapplied, 12'h060);
        vcmd <= 12'h032;
        tick(4);
        chk(vapplied, 12'h032);
        chk(drive_en, 1'b1);
        closed <= 0;
        wr(`MLFD_A_MOTOR, 32'h0000_0000);
        rd_chk(`MLFD_A_FAULT, 32'h0000_0000);
        load <= 12'h0C8;
        tick(6);
        chk(drive_en, 1'b1);
        rd_chk(`MLFD_A_FAULT, 32'h0000_0001);
        wr(`MLFD_A_CTRL, 32'h0001_0701);
        wait_off();
        chk(saw, 1'b1);
        chk(hiz, 1'b1);
        rd_chk(`MLFD_A_FAULT, 32'h0000_0001);
        load <= 12'h000;
        for (k = 0; k < 200 && restart !== 1'b1; k++) @(posedge i_clk);
        chk(restart, 1'b1);
        tick(2);
        rd_chk(`MLFD_A_FAULT, 32'h0000_0000);
        wr(`MLFD_A_CTRL, 32'h0001_0700);
        load <= 12'h064;
        pulse(3'b001, 3);
        for (k = 0; k < 3; k++) pulse(3'b010, 5);
        closed <= 1;
        for (k = 0; k < 4; k++) pulse(3'b100, k == 2 ? 30 : 10);
        rd_chk(`MLFD_A_FAULT, 32'h0000_0038);
        chk(drive_en, 1'b1);
        load <= 12'h000;
        closed <= 0;
        wr(`MLFD_A_LIMIT, 32'h0000_0100);
        short_c <= 1;
        wait_off();
        short_c <= 0;
        chk(saw, 1'b0);
        rd_chk(`MLFD_A_FAULT, 32'h0000_0078);
        for (k = 0; k < 200 && restart !== 1'b1; k++) @(posedge i_clk);
        tick(2);
        rd_chk(`MLFD_A_FAULT, 32'h0000_0000);
        // Kt of one step and speed 64 give a back-EMF of 64 against a command of 50
        wr(`MLFD_A_MOTOR, 32'h0000_0100);
        speed <= 12'h040;
        bemf <= 12'h005;
        tick(3);
        chk(vapplied, 12'h032);
        vcc24 <= 1;
        tick(3);
        chk(vapplied, 12'h040);
        // Ten cycles of back-EMF 5 between half-cycle pulses integrate to 50
        pulse(5'b01000, 9);
        pulse(5'b01000, 2);
        rd_chk(`MLFD_A_STATUS, 32'h0032_0004);
        pulse(5'b00001, 1);
        pulse(5'b10000, 1);
        pulse(5'b00010, 3);
        pulse(5'b00010, 3);
        closed <= 1;
        tick(25);
        rd_chk(`MLFD_A_FAULT, 32'h0000_000E);
        chk(drive_en, 1'b1);
        finish_test();
    end
endmodule
